/* ton_retry_pkg.sv */
// constants, field layouts and carriers for the turn-on timeout retry logic
// assumes a single 25 MHz clock and a synchronous active-high reset
package ton_retry_pkg;
    // command codes on the configuration port
    localparam logic [7:0] CMD_TON_REACTION = 8'h63;
    localparam logic [7:0] CMD_TIME_UNIT = 8'hd2;
    // values after reset
    localparam logic [7:0] REACTION_RESET = 8'h80;
    localparam logic [7:0] TIME_UNIT_RESET = 8'h00;
    // field positions inside the reaction byte
    localparam int RESP_LSB = 6;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_LSB = 0;
    // response codes
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_CONTINUE = 2'h1;
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] RESP_DISABLE_LATCH = 2'h3;
    // retry codes
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // time base: one millisecond tick derived from the clock rate
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // length of one delay time unit, in milliseconds, per unit code
    localparam logic [9:0] UNIT_MS_0 = 10'h001;
    localparam logic [9:0] UNIT_MS_1 = 10'h00a;
    localparam logic [9:0] UNIT_MS_2 = 10'h064;
    localparam logic [9:0] UNIT_MS_3 = 10'h3e8;
    // delay count saturates at the largest selectable count
    localparam logic [7:0] UNITS_MAX = 8'h80;

    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retry;
        logic [2:0] delay;
    } reaction_s;

    typedef struct packed {
        logic wr;
        logic [7:0] code;
        logic [7:0] data;
    } cmd_s;
endpackage : ton_retry_pkg

/* ms_tick_div.sv */
// free-running divider giving a one-cycle pulse every CYCLES clocks
// assumes the parent uses the pulse as its millisecond time base
`timescale 1ns/1ps
`default_nettype none
module ms_tick_div #(
    parameter int CYCLES = 25000
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic tick_q
);
    localparam int W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_q;

    // wrap counter and pulse on the last count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule : ms_tick_div
`default_nettype wire

/* ton_retry_ctrl.sv */
// turn-on timeout fault response: limit timing, retry count and spacing
// assumes ctrl_on merges the control pin and OPERATION; inputs synchronous to clk
// How it works
// - retry code 100 allows up to four restart attempts
// - retry code 101 allows up to five restart attempts
// - retry code 110 allows up to six restart attempts
// - attempts used up: output off until the fault is cleared
// - code 111 retries forever until off or other fault
// - attempts spaced start to start by the selected number of delay units times the unit
// - delay field n selects two to the power n units
// - continue mode keeps running for the delay before retry handling
// - unit length comes from the register at command 0xd2
// - the unit used is the output-voltage fault unit
// - response field: ignore, continue, disable and retry, latch off
// - retry 000 latches off; 001 to 011 give one to three tries
// - fault when output misses its limit; zero limit never faults
// - fault clears by bit clear, clear-all, off then on, or reset
`timescale 1ns/1ps
`default_nettype none
module ton_retry_ctrl #(
    parameter int TICK_CYCLES = ton_retry_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ton_retry_pkg::cmd_s cmd,
    input wire logic [7:0] rd_code,
    output logic [7:0] rd_data_q,
    input wire logic ctrl_on,
    input wire logic other_fault,
    input wire logic vout_above_uv,
    input wire logic [15:0] ton_limit_ms,
    input wire logic clear_bit,
    input wire logic clear_faults,
    output logic out_en_q,
    output logic fault_q,
    output logic [2:0] attempts_q
);
    typedef enum logic [2:0] {OFF, STARTING, RUNNING, CONT_OP, WAIT_RETRY, LATCHED} state_e;

    state_e state_q, state_d;
    ton_retry_pkg::reaction_s reaction_q;
    logic [7:0] unit_reg_q;
    logic [9:0] unit_ms;
    logic [9:0] ms_in_unit_q;
    logic [7:0] unit_cnt_q;
    logic [7:0] delay_units;
    logic [15:0] lim_cnt_q;
    logic ctrl_prev_q;
    logic ms_tick;
    logic timeout;
    logic delay_done;
    logic retry_go;
    logic restart_units;
    logic fail_ev;

    ms_tick_div #(.CYCLES(TICK_CYCLES)) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick_q(ms_tick)
    );

    // configuration writes on the command port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reaction_q <= ton_retry_pkg::reaction_s'(ton_retry_pkg::REACTION_RESET);
            unit_reg_q <= ton_retry_pkg::TIME_UNIT_RESET;
        end else if (cmd.wr) begin
            if (cmd.code == ton_retry_pkg::CMD_TON_REACTION) begin
                reaction_q <= ton_retry_pkg::reaction_s'(cmd.data);
            end
            if (cmd.code == ton_retry_pkg::CMD_TIME_UNIT) begin
                unit_reg_q <= cmd.data;
            end
        end
    end

    // readback of both bytes, zero elsewhere
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
        end else if (rd_code == ton_retry_pkg::CMD_TON_REACTION) begin
            rd_data_q <= reaction_q;
        end else if (rd_code == ton_retry_pkg::CMD_TIME_UNIT) begin
            rd_data_q <= unit_reg_q;
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    always_comb begin
        unique case (unit_reg_q[1:0])
            2'h0: unit_ms = ton_retry_pkg::UNIT_MS_0;
            2'h1: unit_ms = ton_retry_pkg::UNIT_MS_1;
            2'h2: unit_ms = ton_retry_pkg::UNIT_MS_2;
            2'h3: unit_ms = ton_retry_pkg::UNIT_MS_3;
        endcase
    end

    assign delay_units = 8'(8'h01 << reaction_q.delay);
    assign delay_done = (unit_cnt_q >= delay_units);
    assign timeout = (ton_limit_ms != 16'h0000) && (lim_cnt_q >= ton_limit_ms);
    assign fail_ev = (state_q == STARTING) && !vout_above_uv && timeout;
    assign retry_go = (reaction_q.retry == ton_retry_pkg::RETRY_FOREVER) || (attempts_q < reaction_q.retry);

    // next state; commanded off or a foreign fault overrides everything
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            OFF: begin
                state_d = STARTING;
            end
            STARTING: begin
                if (vout_above_uv) begin
                    state_d = RUNNING;
                end else if (timeout) begin
                    unique case (reaction_q.resp)
                        ton_retry_pkg::RESP_IGNORE: state_d = RUNNING;
                        ton_retry_pkg::RESP_CONTINUE: state_d = CONT_OP;
                        ton_retry_pkg::RESP_DISABLE_RETRY: state_d = retry_go ? WAIT_RETRY : LATCHED;
                        ton_retry_pkg::RESP_DISABLE_LATCH: state_d = LATCHED;
                    endcase
                end
            end
            RUNNING: begin
                state_d = RUNNING;
            end
            CONT_OP: begin
                // keep running for the delay, then judge again
                if (delay_done) begin
                    state_d = vout_above_uv ? RUNNING : (retry_go ? WAIT_RETRY : LATCHED);
                end
            end
            WAIT_RETRY: begin
                // next start once the spacing has passed
                if (delay_done) begin
                    state_d = STARTING;
                end
            end
            LATCHED: begin
                // held off until the flag is cleared
                if (!fault_q) begin
                    state_d = OFF;
                end
            end
            default: state_d = OFF;
        endcase
        // off command or other fault stops retrying
        if (!ctrl_on || other_fault) begin
            state_d = OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= OFF;
            out_en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            out_en_q <= (state_d == STARTING) || (state_d == RUNNING) || (state_d == CONT_OP);
        end
    end

    // delay units counted from each attempt start or from the fault in continue mode
    assign restart_units = (state_d != state_q) && ((state_d == STARTING) || (state_d == CONT_OP));

    // unit timer; ms phase is free-running, so the first unit after a restart may be up to 1 ms short
    always_ff @(posedge clk) begin
        if (sys_rst || restart_units) begin
            ms_in_unit_q <= 10'h000;
            unit_cnt_q <= 8'h00;
        end else if (ms_tick) begin
            if (ms_in_unit_q + 10'h001 >= unit_ms) begin
                ms_in_unit_q <= 10'h000;
                if (unit_cnt_q != ton_retry_pkg::UNITS_MAX) begin
                    unit_cnt_q <= unit_cnt_q + 8'h01;
                end
            end else begin
                ms_in_unit_q <= ms_in_unit_q + 10'h001;
            end
        end
    end

    // turn-on limit timer, milliseconds since the attempt began
    always_ff @(posedge clk) begin
        if (sys_rst || state_q != STARTING) begin
            lim_cnt_q <= 16'h0000;
        end else if (ms_tick && lim_cnt_q != 16'hffff) begin
            lim_cnt_q <= lim_cnt_q + 16'h0001;
        end
    end

    // attempt counter
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == OFF) begin
            attempts_q <= 3'h0;
        end else if (state_q == STARTING && vout_above_uv) begin
            attempts_q <= 3'h0;
        end else if (state_q == WAIT_RETRY && state_d == STARTING && attempts_q != 3'h7) begin
            attempts_q <= attempts_q + 3'h1;
        end
    end

    // latched flag; a new timeout wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
            ctrl_prev_q <= 1'b0;
        end else begin
            ctrl_prev_q <= ctrl_on;
            if (fail_ev) begin
                fault_q <= 1'b1;
            end else if (clear_bit || clear_faults || (ctrl_on && !ctrl_prev_q)) begin
                fault_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence retry_launch;
        state_q == WAIT_RETRY && state_d == STARTING;
    endsequence

    sequence give_up;
        state_q == STARTING && fail_ev && reaction_q.resp == ton_retry_pkg::RESP_DISABLE_RETRY && !retry_go;
    endsequence

    // a second cycle may only drive again if the command came back on in between
    off_kills_a: assert property (!ctrl_on |=> (!out_en_q && state_q == OFF) ##1 (!out_en_q || $past(ctrl_on)))
        else $error("output on after off");
    latch_holds_a: assert property (state_q == LATCHED && fault_q |=> !out_en_q ##0 (state_q == LATCHED || state_q == OFF))
        else $error("latched but driving");
    give_up_a: assert property (give_up ##0 (ctrl_on && !other_fault) |=> state_q == LATCHED ##0 !out_en_q)
        else $error("no latch when attempts used");
    four_tries_a: assert property (state_q == WAIT_RETRY && reaction_q.retry == 3'h4 |-> attempts_q < 3'h4)
        else $error("fifth try with code 100");
    five_tries_a: assert property (state_q == WAIT_RETRY && reaction_q.retry == 3'h5 |-> attempts_q < 3'h5)
        else $error("sixth try with code 101");
    six_tries_a: assert property (state_q == WAIT_RETRY && reaction_q.retry == 3'h6 |-> attempts_q < 3'h6)
        else $error("seventh try with code 110");
    spacing_a: assert property (retry_launch |-> unit_cnt_q >= (8'h01 << reaction_q.delay) ##1 out_en_q)
        else $error("restart before spacing");
    success_a: assert property (state_q == STARTING && vout_above_uv && ctrl_on |=> attempts_q == 3'h0)
        else $error("count not reset");
    flag_set_a: assert property (fail_ev |=> fault_q) else $error("timeout not flagged");
    no_limit_a: assert property (ton_limit_ms == 16'h0000 |-> !fail_ev) else $error("fault with zero limit");
    cont_run_a: assert property (state_q == CONT_OP && !delay_done && ctrl_on && !other_fault |=> out_en_q)
        else $error("dropped output in continue mode");
endmodule : ton_retry_ctrl
`default_nettype wire

/* host_model.sv */
// host side of the command port: byte writes, readback, clear-all
// assumes the bench calls its tasks; lines move 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output var ton_retry_pkg::cmd_s cmd,
    output logic [7:0] rd_code,
    output logic clear_faults
);
    initial begin
        cmd = '0;
        rd_code = 8'h00;
        clear_faults = 1'b0;
    end
    // one-cycle strobe; data inverted on release so stale bytes never match
    task automatic put(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk);
        #1;
        cmd = '{wr: 1'b1, code: code, data: data};
        @(posedge clk);
        #1;
        cmd = '{wr: 1'b0, code: ~code, data: ~data};
    endtask : put
    // readback is registered, so take it one edge after the code
    task automatic get(input logic [7:0] code, output logic [7:0] data);
        @(posedge clk);
        #1;
        rd_code = code;
        @(posedge clk);
        #1;
        data = rd_data;
    endtask : get
    task automatic clear_all();
        @(posedge clk);
        #1;
        clear_faults = 1'b1;
        @(posedge clk);
        #1;
        clear_faults = 1'b0;
    endtask : clear_all
endmodule : host_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the turn-on timeout retry logic
// assumes TICK_CYCLES of 4, so one millisecond is four clocks
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, sys_rst, ctrl_on, other_fault, vout_above_uv, clear_bit, clear_faults;
    ton_retry_pkg::cmd_s cmd;
    logic [7:0] rd_code, rd_data, rd;
    logic [15:0] lim;
    logic out_en, fault;
    logic [2:0] att;
    int num_errors = 0, n_checks = 0, starts, gap;
    host_model host_model_i (.clk(clk), .rd_data(rd_data), .cmd(cmd), .rd_code(rd_code),
        .clear_faults(clear_faults));
    ton_retry_ctrl #(.TICK_CYCLES(4)) ton_retry_ctrl_i (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
        .rd_code(rd_code), .rd_data_q(rd_data), .ctrl_on(ctrl_on), .other_fault(other_fault),
        .vout_above_uv(vout_above_uv), .ton_limit_ms(lim), .clear_bit(clear_bit),
        .clear_faults(clear_faults), .out_en_q(out_en), .fault_q(fault), .attempts_q(att));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic rng(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : rng
    // off first, so the clear and the new byte act from a clean state
    task automatic start(input logic [7:0] react, input logic [7:0] unit);
        ctrl_on = 1'b0;
        host_model_i.clear_all();
        chk("clear all", 0, fault);
        host_model_i.put(8'h63, react);
        host_model_i.put(8'hd2, unit);
        ctrl_on = 1'b1;
    endtask : start
    // counts output starts; gap holds the last start-to-start spacing
    task automatic watch(input int n);
        int last;
        logic prev;
        last = 0;
        prev = out_en;
        starts = 0;
        for (int c = 1; c <= n; c++) begin
            @(posedge clk);
            #1;
            if (out_en === 1'b1 && prev !== 1'b1) begin
                starts++;
                gap = c - last;
                last = c;
            end
            prev = out_en;
        end
    endtask : watch
    task automatic t_regs();
        host_model_i.get(8'h63, rd);
        chk("reaction reset", 8'h80, rd);
        host_model_i.get(8'hd2, rd);
        chk("unit reset", 8'h00, rd);
        host_model_i.put(8'hd2, 8'hfd);
        host_model_i.get(8'hd2, rd);
        chk("unit byte", 8'hfd, rd);
        host_model_i.get(8'h64, rd);
        chk("unmapped", 8'h00, rd);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_count();
        lim = 16'h0001;
        for (int k = 0; k < 7; k++) begin
            start({2'h2, k[2:0], 3'h2}, 8'h00);
            watch(400);
            chk("starts", k + 1, starts);
            chk("attempts", k, att);
            chk("output off", 0, out_en);
            chk("fault set", 1, fault);
        end
        lim = 16'h0000;
        clear_bit = 1'b1;
        watch(1);
        clear_bit = 1'b0;
        watch(20);
        chk("bit clear", 0, fault);
        chk("restart", 1, starts);
        $display("t_count done");
    endtask : t_count
    task automatic t_gap();
        logic [7:0] u[5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
        logic [2:0] d[5] = '{3'h3, 3'h7, 3'h1, 3'h0, 3'h0};
        int e[5] = '{32, 512, 80, 400, 4000};
        lim = 16'h0001;
        for (int i = 0; i < 5; i++) begin
            start({2'h2, 3'h7, d[i]}, u[i]);
            watch(2 * e[i] + 20);
            rng("spacing", e[i] - 5, e[i] + 5, gap);
        end
        $display("t_gap done");
    endtask : t_gap
    task automatic t_forever();
        start(8'hb9, 8'h00);
        watch(200);
        rng("endless", 9, 200, starts);
        ctrl_on = 1'b0;
        watch(100);
        chk("off starts", 0, starts);
        chk("off out", 0, out_en);
        ctrl_on = 1'b1;
        other_fault = 1'b1;
        watch(50);
        chk("held off", 0, starts);
        chk("on clears", 0, fault);
        other_fault = 1'b0;
        $display("t_forever done");
    endtask : t_forever
    task automatic t_modes();
        lim = 16'h0001;
        start(8'h00, 8'h00);
        watch(100);
        chk("ignore out", 1, out_en);
        chk("ignore flag", 1, fault);
        start(8'h43, 8'h00);
        watch(20);
        chk("run on", 1, out_en);
        watch(60);
        chk("run off", 0, out_en);
        start(8'hf8, 8'h00);
        watch(100);
        chk("latch starts", 1, starts);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_success();
        start(8'hb2, 8'h00);
        watch(40);
        rng("tries made", 1, 6, att);
        vout_above_uv = 1'b1;
        watch(30);
        chk("tries reset", 0, att);
        chk("running", 1, out_en);
        vout_above_uv = 1'b0;
        lim = 16'h0000;
        start(8'h80, 8'h00);
        watch(200);
        chk("no limit", 0, fault);
        $display("t_success done");
    endtask : t_success
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        {sys_rst, ctrl_on, other_fault, vout_above_uv, clear_bit, lim} = {5'h10, 16'h0000};
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_regs();
        t_count();
        t_gap();
        t_forever();
        t_modes();
        t_success();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("[FAIL] run time expected done seen hang");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
